// >>> hdl/rbf_map.vh
// Register map, field positions and codes of the receive bit-framing block
`ifndef RBF_MAP_VH
`define RBF_MAP_VH

// Register indices; the byte address is four times the index
`define RBF_IDX_STATUS   6'h0B
`define RBF_IDX_BITCTRL  6'h0C
`define RBF_IDX_COLL     6'h0D
`define RBF_IDX_CMD      6'h10
`define RBF_IDX_EVENT    6'h11
`define RBF_IDX_MASK     6'h12

// Bit-framing control fields
`define RBF_KEEP_BIT     7
`define RBF_OFS_HI       6
`define RBF_OFS_LO       4
`define RBF_COLLISION_AS_INTEGRITY_ERROR_BIT   3
`define RBF_CTRL_WMASK   8'hF8
`define RBF_BITCTRL_RST  8'h00

// Collision position fields
`define RBF_CVALID_BIT   7
`define RBF_COLL_LIMIT   8'h40

// Transceiver state codes
`define RBF_ST_IDLE      3'h0
`define RBF_ST_TRANSMIT_WAIT_STATE    3'h1
`define RBF_ST_TX        3'h3
`define RBF_ST_RECEIVE_WAIT_STATE    3'h5
`define RBF_ST_WAITDATA  3'h6
`define RBF_ST_RX        3'h7

// Command codes
`define RBF_CMD_IDLE     2'h0
`define RBF_CMD_RECV     2'h1
`define RBF_CMD_TRCV     2'h2

// Event bits
`define RBF_EV_INTEG     0
`define RBF_EV_COLL      1
`define RBF_EV_DONE      2

// Bus responses
`define RBF_RESP_OKAY    2'h0
`define RBF_RESP_SLVERR  2'h2

`endif

// >>> hdl/rbf_sync2.v
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module rbf_sync2 #(
  parameter WIDTH = 7
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// >>> hdl/rbf_rx_framing.v
// Receive bit framing, collision capture and transceiver state with AXI4-Lite registers
`timescale 1ns/1ps
`include "rbf_map.vh"

// Contract
// RQ1 - State machine shown as fixed 3-bit code
// RQ2 - Bits after collision stored zero unless kept
// RQ3 - First bit stored at offset, then upward
// RQ4 - Offset seven wraps second bit to next byte
// RQ5 - Zero offset means byte-oriented reception
// RQ6 - Collision raises integrity error when enabled
// RQ7 - Last byte valid bit count, zero whole
// RQ8 - Valid bit count loaded at end, cleared start
// RQ9 - Index valid only when index is meaningful
// RQ10 - Index of first collision, data bits only
// RQ11 - Zero-based index, first eight bytes only
// RQ12 - Nonzero offset added into collision index
// RQ13 - Host uses index only when valid set
// RQ14 - No collision flag inside end-of-frame symbol
// RQ15 - Collision flag cleared entering wait-for-data
// RQ16 - Index and valid cleared at reception start
// RQ17 - Reserved status bits read zero, ignore writes
module rbf_rx_framing #(
  parameter [15:0] RX_WAIT_CYCLES = 16'h0010
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        link_tx_done,
  input  wire        link_sof,
  input  wire        link_eof,
  input  wire        link_bit_strobe,
  input  wire        link_bit_data,
  input  wire        link_bit_coll,
  input  wire        link_coll_in_eof,
  output wire [2:0]  link_state_code,
  output wire [7:0]  rx_byte_data,
  output wire        rx_byte_valid,
  output wire        irq
);

  localparam ST_IDLE     = `RBF_ST_IDLE;
  localparam ST_TRANSMIT_WAIT_STATE   = `RBF_ST_TRANSMIT_WAIT_STATE;
  localparam ST_TX       = `RBF_ST_TX;
  localparam ST_RECEIVE_WAIT_STATE   = `RBF_ST_RECEIVE_WAIT_STATE;
  localparam ST_WAITDATA = `RBF_ST_WAITDATA;
  localparam ST_RX       = `RBF_ST_RX;

  // Address decode shared by the read and write paths
  function addr_hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      addr_hit = (addr[7:2] == idx);
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = addr_hit(addr, `RBF_IDX_STATUS) | addr_hit(addr, `RBF_IDX_BITCTRL) |
               addr_hit(addr, `RBF_IDX_COLL) | addr_hit(addr, `RBF_IDX_CMD) |
               addr_hit(addr, `RBF_IDX_EVENT) | addr_hit(addr, `RBF_IDX_MASK);
    end
  endfunction

  // Link pins are asynchronous: synchronise before any use
  wire [6:0] pin_sync;
  reg  [6:0] pin_prev_reg;

  rbf_sync2 #(
    .WIDTH (7)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({link_coll_in_eof, link_bit_coll, link_bit_data, link_bit_strobe,
                link_eof, link_sof, link_tx_done}),
    .sync_out (pin_sync)
  );

  wire tx_done_rise = pin_sync[0] & ~pin_prev_reg[0];
  wire sof_rise     = pin_sync[1] & ~pin_prev_reg[1];
  wire eof_rise     = pin_sync[2] & ~pin_prev_reg[2];
  wire bit_rise     = pin_sync[3] & ~pin_prev_reg[3];
  wire bit_data     = pin_sync[4];
  wire bit_coll     = pin_sync[5];
  wire coll_in_eof  = pin_sync[6];

  // AXI4-Lite state
  reg        aw_have_reg;
  reg        w_have_reg;
  reg [7:0]  awaddr_reg;
  reg [7:0]  wdata_reg;
  reg        wlane_reg;
  reg        awready_reg;
  reg        wready_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        arready_reg;
  reg        rvalid_reg;
  reg [1:0]  rresp_reg;
  reg [7:0]  rdata_reg;

  // Block state
  reg [2:0]  state_reg;
  reg [15:0] wait_cnt_reg;
  reg [7:0]  bitctrl_reg;
  reg [7:0]  coll_reg;
  reg [2:0]  event_reg;
  reg [2:0]  mask_reg;
  reg [2:0]  bit_pos_reg;
  reg [7:0]  acc_reg;
  reg [6:0]  dbit_cnt_reg;
  reg        coll_seen_reg;
  reg [7:0]  byte_out_reg;
  reg        byte_valid_reg;
  reg        irq_reg;

  wire [2:0] bit_offset = bitctrl_reg[`RBF_OFS_HI:`RBF_OFS_LO];
  wire       keep_bits  = bitctrl_reg[`RBF_KEEP_BIT];
  wire       coll_integ = bitctrl_reg[`RBF_COLLISION_AS_INTEGRITY_ERROR_BIT];

  wire aw_hs   = s_axi_awvalid & awready_reg;
  wire w_hs    = s_axi_wvalid & wready_reg;
  wire ar_hs   = s_axi_arvalid & arready_reg;
  wire wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire wr_en   = wr_fire & wlane_reg;

  wire aw_have_next = wr_fire ? 1'b0 : (aw_have_reg | aw_hs);
  wire w_have_next  = wr_fire ? 1'b0 : (w_have_reg | w_hs);
  wire bvalid_next  = wr_fire | (bvalid_reg & ~s_axi_bready);
  wire rvalid_next  = ar_hs | (rvalid_reg & ~s_axi_rready);

  // Write channel: address and data taken in either order, one write at a time
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RBF_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
        awaddr_reg <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
        bresp_reg <= mapped(awaddr_reg) ? `RBF_RESP_OKAY : `RBF_RESP_SLVERR;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      bvalid_reg  <= bvalid_next;
      awready_reg <= ~aw_have_next & ~bvalid_next;
      wready_reg  <= ~w_have_next & ~bvalid_next;
    end
  end

  // Read data selection; narrow registers sit in the low byte
  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = 8'h00;
    // RQ17 reserved status bits
    if (addr_hit(s_axi_araddr, `RBF_IDX_STATUS))
      rd_mux = {5'h00, state_reg};
    else if (addr_hit(s_axi_araddr, `RBF_IDX_BITCTRL))
      rd_mux = bitctrl_reg;
    else if (addr_hit(s_axi_araddr, `RBF_IDX_COLL))
      rd_mux = coll_reg;
    else if (addr_hit(s_axi_araddr, `RBF_IDX_EVENT))
      rd_mux = {5'h00, event_reg};
    else if (addr_hit(s_axi_araddr, `RBF_IDX_MASK))
      rd_mux = {5'h00, mask_reg};
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `RBF_RESP_OKAY;
      rdata_reg   <= 8'h00;
    end
    else
    begin
      if (ar_hs)
      begin
        rdata_reg <= rd_mux;
        rresp_reg <= mapped(s_axi_araddr) ? `RBF_RESP_OKAY : `RBF_RESP_SLVERR;
      end
      rvalid_reg  <= rvalid_next;
      arready_reg <= ~rvalid_next;
    end
  end

  wire       cmd_wr   = wr_en & addr_hit(awaddr_reg, `RBF_IDX_CMD);
  wire [1:0] cmd_code = wdata_reg[1:0];

  // Reception datapath terms
  wire       in_rx     = (state_reg == ST_RX);
  wire       rx_bit    = in_rx & bit_rise;
  // RQ14 EOF collisions masked
  wire       coll_now  = rx_bit & bit_coll & ~coll_in_eof;
  // RQ2 zero after collision
  wire       store_bit = (coll_seen_reg & ~keep_bits) ? 1'b0 : bit_data;
  // RQ12 offset added into index
  wire [7:0] coll_pos  = {1'b0, dbit_cnt_reg} + {5'h00, bit_offset};
  wire       frame_end = in_rx & eof_rise;
  wire       enter_wd  = (state_reg != ST_WAITDATA) &&
                         ((cmd_wr && cmd_code == `RBF_CMD_RECV) ||
                          (state_reg == ST_RECEIVE_WAIT_STATE && wait_cnt_reg == 16'h0000));
  wire       rx_start  = (state_reg == ST_WAITDATA) & sof_rise;

  // Transceiver state machine
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= ST_IDLE;
      wait_cnt_reg <= 16'h0000;
    end
    else if (cmd_wr)
    begin
      case (cmd_code)
        `RBF_CMD_RECV: state_reg <= ST_WAITDATA;
        `RBF_CMD_TRCV: state_reg <= ST_TRANSMIT_WAIT_STATE;
        default:       state_reg <= ST_IDLE;
      endcase
    end
    else
    begin
      // RQ1 state codes
      case (state_reg)
        ST_TRANSMIT_WAIT_STATE:
          state_reg <= ST_TX;
        ST_TX:
          if (tx_done_rise)
          begin
            state_reg    <= ST_RECEIVE_WAIT_STATE;
            wait_cnt_reg <= RX_WAIT_CYCLES;
          end
        ST_RECEIVE_WAIT_STATE:
          if (wait_cnt_reg == 16'h0000)
            state_reg <= ST_WAITDATA;
          else
            wait_cnt_reg <= wait_cnt_reg - 16'h0001;
        ST_WAITDATA:
          if (sof_rise)
            state_reg <= ST_RX;
        ST_RX:
          if (eof_rise)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Bit placement, byte assembly and collision capture
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_prev_reg   <= 7'h00;
      bitctrl_reg    <= `RBF_BITCTRL_RST;
      coll_reg       <= 8'h00;
      bit_pos_reg    <= 3'h0;
      acc_reg        <= 8'h00;
      dbit_cnt_reg   <= 7'h00;
      coll_seen_reg  <= 1'b0;
      byte_out_reg   <= 8'h00;
      byte_valid_reg <= 1'b0;
    end
    else
    begin
      pin_prev_reg   <= pin_sync;
      byte_valid_reg <= 1'b0;
      // Only the upper five control bits are software-writable
      if (wr_en && addr_hit(awaddr_reg, `RBF_IDX_BITCTRL))
        bitctrl_reg[7:3] <= wdata_reg[7:3];
      if (rx_start)
      begin
        // RQ3 start at offset
        bit_pos_reg   <= bit_offset;
        acc_reg       <= 8'h00;
        dbit_cnt_reg  <= 7'h00;
        coll_seen_reg <= 1'b0;
        // RQ16 clear stale collision
        coll_reg      <= 8'h00;
        // RQ8 cleared at start
        bitctrl_reg[2:0] <= 3'h0;
      end
      else if (rx_bit)
      begin
        // RQ3 place bit upward
        acc_reg[bit_pos_reg] <= store_bit;
        if (dbit_cnt_reg != 7'h7F)
          dbit_cnt_reg <= dbit_cnt_reg + 7'h01;
        // RQ4 wrap to next byte
        if (bit_pos_reg == 3'h7)
        begin
          byte_out_reg   <= {store_bit, acc_reg[6:0]};
          byte_valid_reg <= 1'b1;
          acc_reg        <= 8'h00;
          bit_pos_reg    <= 3'h0;
        end
        else
          bit_pos_reg <= bit_pos_reg + 3'h1;
        if (coll_now && !coll_seen_reg)
        begin
          coll_seen_reg <= 1'b1;
          // RQ10 first collision index
          coll_reg[6:0] <= coll_pos[6:0];
          // RQ9 RQ11 valid inside first 8 bytes
          coll_reg[`RBF_CVALID_BIT] <= (coll_pos < `RBF_COLL_LIMIT);
        end
      end
      else if (frame_end)
      begin
        // A partial last byte is still handed on
        if (bit_pos_reg != 3'h0)
        begin
          byte_out_reg   <= acc_reg;
          byte_valid_reg <= 1'b1;
        end
        // RQ5 RQ7 RQ8 valid bits loaded when bit-oriented
        if (bit_offset != 3'h0)
          bitctrl_reg[2:0] <= bit_pos_reg;
      end
    end
  end

  // Event flags: hardware set beats both software and hardware clears
  reg [2:0] ev_set;
  reg [2:0] ev_clr;
  always @*
  begin
    ev_set = 3'h0;
    ev_clr = 3'h0;
    ev_set[`RBF_EV_COLL]  = coll_now;
    // RQ6 collision as integrity error
    ev_set[`RBF_EV_INTEG] = coll_now & coll_integ;
    ev_set[`RBF_EV_DONE]  = frame_end;
    if (wr_en && addr_hit(awaddr_reg, `RBF_IDX_EVENT))
      ev_clr = wdata_reg[2:0];
    // RQ15 clear on wait-for-data entry
    if (enter_wd)
    begin
      ev_clr[`RBF_EV_COLL]  = 1'b1;
      ev_clr[`RBF_EV_INTEG] = 1'b1;
    end
  end

  // Interrupt status, mask and level output
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_reg <= 3'h0;
      mask_reg  <= 3'h0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      event_reg <= (event_reg & ~ev_clr) | ev_set;
      if (wr_en && addr_hit(awaddr_reg, `RBF_IDX_MASK))
        mask_reg <= wdata_reg[2:0];
      irq_reg <= |(event_reg & mask_reg);
    end
  end

  assign s_axi_awready   = awready_reg;
  assign s_axi_wready    = wready_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_arready   = arready_reg;
  assign s_axi_rdata     = {24'h000000, rdata_reg};
  assign s_axi_rresp     = rresp_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign link_state_code = state_reg;
  assign rx_byte_data    = byte_out_reg;
  assign rx_byte_valid   = byte_valid_reg;
  assign irq             = irq_reg;

endmodule

// >>> tb/rbf_rx_framing_assertions.sv
// Protocol and state assertions for the receive bit-framing block
`timescale 1ns/1ps
`include "rbf_map.vh"
module rbf_rx_framing_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        link_sof,
  input wire [2:0]  link_state_code,
  input wire        rx_byte_valid,
  input wire        irq
);
  reg st_rd_reg;
  // Remember whether the read under way targets the state register
  always @(posedge aclk)
    if (!aresetn)
      st_rd_reg <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      st_rd_reg <= (s_axi_araddr == {`RBF_IDX_STATUS, 2'b00});
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  no_code_four_a:
    assert property (link_state_code != 3'h4) else $error("unused state code shown");
  transmit_wait_state_step_a:
    assert property (link_state_code == `RBF_ST_TRANSMIT_WAIT_STATE |=>
      link_state_code inside {`RBF_ST_TX, `RBF_ST_IDLE}) else $error("bad exit from tx wait");
  idle_exit_a:
    assert property (link_state_code == `RBF_ST_IDLE |=> link_state_code inside
      {`RBF_ST_IDLE, `RBF_ST_TRANSMIT_WAIT_STATE, `RBF_ST_WAITDATA}) else $error("bad exit from idle");
  sof_start_a:
    assert property (link_state_code == `RBF_ST_WAITDATA && $rose(link_sof) |->
      ##[1:5] link_state_code == `RBF_ST_RX) else $error("frame start not taken");
  byte_pulse_a:
    assert property (rx_byte_valid |=> !rx_byte_valid) else $error("byte strobe too long");
  status_zero_a:
    assert property (s_axi_rvalid && st_rd_reg |-> s_axi_rdata[31:3] == 29'h0)
      else $error("reserved state bits not zero");
  resp_once_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
  read_once_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
  write_busy_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
  cover property (link_state_code == `RBF_ST_RX && rx_byte_valid);
  cover property ($rose(irq));
  cover property (link_state_code == `RBF_ST_TRANSMIT_WAIT_STATE);
endmodule
bind rbf_rx_framing rbf_rx_framing_chk u_chk (.*);

// >>> tb/rbf_tag_model.sv
// Behavioural remote tag driving the receive link pins
`timescale 1ns/1ps
module rbf_tag_model (
  input  wire  aclk,
  output logic link_tx_done,
  output logic link_sof,
  output logic link_eof,
  output logic link_bit_strobe,
  output logic link_bit_data,
  output logic link_bit_coll,
  output logic link_coll_in_eof
);
  // Levels held four cycles so the three-flop sampler never misses one
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // All pins quiet from time zero
  initial
  begin
    {link_tx_done, link_sof, link_eof, link_bit_strobe} = 4'h0;
    {link_bit_data, link_bit_coll, link_coll_in_eof} = 3'h0;
  end
  // End of the reader's own transmission
  task automatic tx_end;
    link_tx_done <= 1'b1;
    hold(4);
    link_tx_done <= 1'b0;
    hold(4);
  endtask
  task automatic frame(input int n, input logic [79:0] b, input int cp, input logic ce);
    link_sof <= 1'b1;
    link_coll_in_eof <= ce;
    hold(4);
    for (int i = 0; i < n; i++)
    begin
      link_bit_data <= b[i];
      link_bit_coll <= (i == cp);
      link_bit_strobe <= 1'b1;
      hold(4);
      // Released data line flips so a stale value is never read
      link_bit_data <= ~b[i];
      link_bit_strobe <= 1'b0;
      hold(4);
    end
    link_eof <= 1'b1;
    hold(4);
    {link_sof, link_eof, link_coll_in_eof} <= 3'h0;
    hold(8);
  endtask
endmodule

// >>> tb/tb_rbf_rx_framing.sv
// Self-checking bench for the receive bit-framing block
`timescale 1ns/1ps
`include "rbf_map.vh"
module tb_rbf_rx_framing;
  localparam logic [7:0] A_ST = {`RBF_IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CT = {`RBF_IDX_BITCTRL, 2'b00};
  localparam logic [7:0] A_CO = {`RBF_IDX_COLL, 2'b00};
  localparam logic [7:0] A_CM = {`RBF_IDX_CMD, 2'b00};
  localparam logic [7:0] A_EV = {`RBF_IDX_EVENT, 2'b00};
  localparam logic [7:0] A_MK = {`RBF_IDX_MASK, 2'b00};
  localparam logic [1:0] OK = `RBF_RESP_OKAY;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         link_tx_done, link_sof, link_eof, link_bit_strobe, link_bit_data;
  wire         link_bit_coll, link_coll_in_eof, rx_byte_valid, irq;
  wire [2:0]   link_state_code;
  wire [7:0]   rx_byte_data;
  int          err_total = 0;
  int          checks = 0;
  logic [7:0]  got_q[$];
  logic [31:0] d;
  rbf_rx_framing u_dut (.*);
  rbf_tag_model u_tag (.*);
  always #5 aclk = ~aclk;
  // Collect every stored byte the block emits
  always @(posedge aclk)
    if (rx_byte_valid === 1'b1)
      got_q.push_back(rx_byte_data);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: 0x%h, expected 0x%h", $time, got, exp);
    end
  endtask
  task automatic qc(input logic [7:0] e);
    check(32'(got_q.pop_front()), 32'(e));
  endtask
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    do
      @(posedge aclk);
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
      @(posedge aclk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, OK);
    check(d, e);
  endtask
  task automatic t_regs;
    rdc(A_ST, 32'h0);
    rdc(A_CO, 32'h0);
    rd(8'h00, `RBF_RESP_SLVERR);
    check(d, 32'h0);
    wr(A_CM, 8'h01, OK);
    rdc(A_ST, 32'(`RBF_ST_WAITDATA));
    wr(A_CM, 8'h00, OK);
    wr(A_ST, 8'hFF, OK);
    rdc(A_ST, 32'(`RBF_ST_IDLE));
    wr(8'hFC, 8'h12, `RBF_RESP_SLVERR);
    wr(A_CT, 8'hFF, OK);
    rdc(A_CT, 32'hF8);
  endtask
  // Offset four, collision on the fourth bit, later bits zeroed
  task automatic t_align;
    wr(A_MK, 8'h07, OK);
    wr(A_CT, 8'h48, OK);
    wr(A_CM, 8'h01, OK);
    u_tag.frame(7, 80'h7F, 3, 1'b0);
    qc(8'hF0);
    qc(8'h00);
    rdc(A_CT, 32'h4B);
    rdc(A_CO, 32'h87);
    rdc(A_EV, 32'h07);
    check(32'(irq), 32'h1);
    wr(A_EV, 8'h07, OK);
    rdc(A_EV, 32'h00);
    check(32'(irq), 32'h0);
  endtask
  // Offset seven wraps, bits kept, interrupt masked
  task automatic t_wrap;
    wr(A_MK, 8'h00, OK);
    wr(A_CT, 8'hF0, OK);
    wr(A_CM, 8'h01, OK);
    u_tag.frame(5, 80'h1F, 1, 1'b0);
    qc(8'h80);
    qc(8'h0F);
    rdc(A_CT, 32'hF4);
    rdc(A_CO, 32'h88);
    rdc(A_EV, 32'h06);
    check(32'(irq), 32'h0);
  endtask
  // Transceive walk, byte mode, collision inside the end symbol
  task automatic t_trcv;
    wr(A_CT, 8'h00, OK);
    wr(A_CM, 8'h02, OK);
    repeat (3) @(posedge aclk);
    check(32'(link_state_code), 32'(`RBF_ST_TX));
    u_tag.tx_end();
    check(32'(link_state_code), 32'(`RBF_ST_RECEIVE_WAIT_STATE));
    repeat (20) @(posedge aclk);
    check(32'(link_state_code), 32'(`RBF_ST_WAITDATA));
    rdc(A_EV, 32'h04);
    u_tag.frame(8, 80'hA5, 6, 1'b1);
    qc(8'hA5);
    rdc(A_CT, 32'h00);
    rdc(A_CO, 32'h00);
    rdc(A_EV, 32'h04);
    check(32'(link_state_code), 32'(`RBF_ST_IDLE));
  endtask
  // Last reportable bit, then the first one out of range
  task automatic t_far;
    wr(A_CM, 8'h01, OK);
    u_tag.frame(65, 80'h0, 63, 1'b0);
    rdc(A_CO, 32'hBF);
    wr(A_CM, 8'h01, OK);
    u_tag.frame(65, 80'h0, 64, 1'b0);
    rd(A_CO, OK);
    check(d & 32'h80, 32'h0);
    got_q.delete();
  endtask
  task automatic finish_test;
    $display("checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_align();
    t_wrap();
    t_trcv();
    t_far();
    finish_test();
  end
  // Cuts a hang short; the whole run needs about 1500 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test();
  end
endmodule
